/* File: core/result_bank.sv */
/*
 * Four 10-bit result registers and the lower-byte holding register.
 * Assumes the sequencer pulses rd_upper_i once per upper-byte read.
 */
`timescale 1ns/100ps
module result_bank (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       wr_i,
    input  wire logic [1:0] wr_sel_i,
    input  wire logic [9:0] wr_data_i,
    input  wire logic       rd_upper_i,
    input  wire logic [1:0] rd_sel_i,
    output logic [7:0]      upper_o,
    output logic [7:0]      hold_o
);
    sar_adc_pkg::bank_state_s s, s_next;

    // An upper read copies the old lower bits, so both bytes come from one result.
    always_comb begin
        s_next = s;
        if (wr_i) s_next.res[wr_sel_i] = wr_data_i;
        if (rd_upper_i) s_next.hold = {s.res[rd_sel_i][1:0], 6'h00};
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) s <= '0;
        else          s <= s_next;
    end

    assign upper_o = s.res[rd_sel_i][9:2];
    assign hold_o  = s.hold;
endmodule : result_bank

/* File: core/sar_adc_defs.svh */
/*
 * Register indices, field positions, reset values and phase lengths of the converter sequencer.
 * Assumes one state equals one clk_i period and that includers need no other definitions.
 */
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH
// Register indices; the APB byte address is four times the index.
`define IDX_RES_A_HI 8'h20
`define IDX_RES_A_LO 8'h21
`define IDX_RES_B_HI 8'h22
`define IDX_RES_B_LO 8'h23
`define IDX_RES_C_HI 8'h24
`define IDX_RES_C_LO 8'h25
`define IDX_RES_D_HI 8'h26
`define IDX_RES_D_LO 8'h27
`define IDX_CSR      8'h28
`define IDX_TCR      8'h29
// Field positions of the control/status and trigger control registers.
`define CSR_FLAG     7
`define CSR_IRQEN    6
`define CSR_START    5
`define CSR_SWEEP    4
`define CSR_SPEED    3
`define CSR_CH_MSB   2
`define TCR_TIMER_TRIGGER_ENABLE     7
// Reset values, fixed read values and the reserved channel code.
`define CSR_RST      8'h00
`define TCR_RSVD     7'h7F
`define CH_RESERVED  3'h7
// Phase, conversion and sweep period lengths in states, slow and fast speed settings; result width in bits.
`define DLY_SLOW     10
`define DLY_FAST     6
`define SPL_SLOW     64
`define SPL_FAST     32
`define CONV_SLOW    259
`define CONV_FAST    131
`define PER_SLOW     256
`define PER_FAST     128
`define SAR_BITS     10
`endif

/* File: core/sar_adc_pkg.sv */
/*
 * Types shared by the converter sequencer and its two leaf modules.
 * Assumes the constants of sar_adc_defs.svh are included where widths are needed.
 */
package sar_adc_pkg;
    // Phases of one conversion, one-hot.
    typedef enum logic [3:0] {
        PH_IDLE   = 4'b0001,
        PH_DELAY  = 4'b0010,
        PH_SAMPLE = 4'b0100,
        PH_CMP    = 4'b1000
    } phase_e;
    // Signals toward the analog front end.
    typedef struct packed {
        logic [2:0] channel;
        logic       sample;
        logic [9:0] dac_code;
    } analog_out_s;
    // Sequencer state.
    typedef struct packed {
        phase_e      phase;
        logic [8:0]  cnt;
        logic        end_flag;
        logic        armed;
        logic        irq_en;
        logic        start;
        logic        sweep;
        logic        speed;
        logic [2:0]  ch;
        logic        trig_en;
        logic [2:0]  cur;
        logic [31:0] prdata;
    } ctrl_state_s;
    typedef struct packed { logic [9:0] code; logic [9:0] mask; } sar_state_s;
    typedef struct packed { logic [3:0][9:0] res; logic [7:0] hold; } bank_state_s;
endpackage : sar_adc_pkg

/* File: core/sar_adc_sequencer.sv */
/*
 * Sequencer of a 10-bit successive-approximation converter with seven inputs in two groups,
 * its APB register file, result registers and conversion-end interrupt request.
 * Assumes an APB master on clk_i, a one-cycle trigger pulse from the pulse timer unit and
 * an analog front end that samples while sample is high and answers on comparator_i.
 */
//
// Behaviour
// - Timer trigger starts conversion only while trigger enable is 1.
// - Trigger control bits 6 to 0 read 1; software writes 1.
// - Upper result byte read directly, lower byte through a holding register.
// - Upper read returns upper byte and copies lower byte into holding register.
// - Ten-bit successive approximation with single and sweep modes only.
// - Single mode: start flag stays 1 during conversion, clears itself at end.
// - Single completion stores result, sets end flag, clears start, goes idle.
// - End flag and interrupt enable both 1 raise the interrupt request.
// - End flag clears only by writing 0 after reading 1; writing 1 does nothing.
// - Sweep starts at input 0 for group 0, input 4 for group 1.
// - Next sweep channel starts as soon as the previous one finishes.
// - Sweep repeats over selected channels until software clears start.
// - End flag set after each sweep round; sweep restarts at first channel.
// - Restarted sweep begins at the group's first channel.
// - Sampling begins 10 states (slow) or 6 states (fast) after start.
// - Sampling lasts 64 states slow, 32 states fast.
// - First conversion takes 259 states slow, 131 states fast.
// - Later sweep conversions take exactly 256 states slow, 128 fast.
// - A detected trigger sets start and behaves as a software start.
// - Upper byte holds bits 9 to 2; lower bits 7 to 6 hold bits 1 to 0.
// - Inputs 0,4 to A; 1,5 to B; 2,6 to C; 3 to D.
// - Three-bit channel field selects input or sweep range; code 111 reserved.
// - Speed select 0 gives 266 states maximum, 1 gives 134 states.
`timescale 1ns/100ps
`include "sar_adc_defs.svh"
module sar_adc_sequencer (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [11:0]          paddr_i,
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [31:0]          pwdata_i,
    output logic [31:0]               prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    input  wire logic                 trigger_i,
    input  wire logic                 comparator_i,
    output sar_adc_pkg::analog_out_s  analog_o,
    output logic                      conv_end_interrupt_o
);
    ////////////////////////////////////////////////////////////////////////////////////////////
    sar_adc_pkg::ctrl_state_s s, s_next;
    logic        setup, access;
    logic        hit_csr, hit_tcr, hit_res, mapped;
    logic [7:0]  res_idx;
    logic        csr_wr, tcr_wr, done;
    logic        sar_load, sar_step_en, sar_done;
    logic [9:0]  sar_code;
    logic [7:0]  res_upper, res_hold;
    logic [7:0]  csr_val;
    logic [2:0]  ch_new;

    // True when the address is an aligned word at the given register index.
    function automatic logic reg_hit(input logic [11:0] a, input logic [7:0] idx);
        return (a[1:0] == 2'b00) && (a[11:10] == 2'b00) && (a[9:2] == idx);
    endfunction : reg_hit

    // Counter load for a phase: 0 first delay, 1 sampling, 2 comparing, 3 sweep gap.
    // The first delay loses one state to the idle cycle that sees start.
    function automatic logic [8:0] phase_load(input logic [1:0] which, input logic fast);
        int dly, spl, cmp, per, n;
        dly = fast ? `DLY_FAST  : `DLY_SLOW;
        spl = fast ? `SPL_FAST  : `SPL_SLOW;
        per = fast ? `PER_FAST  : `PER_SLOW;
        cmp = (fast ? `CONV_FAST : `CONV_SLOW) - dly - spl;
        case (which)
            2'd0:    n = dly - 2;
            2'd1:    n = spl - 1;
            2'd2:    n = cmp - 1;
            default: n = per - spl - cmp - 1;
        endcase
        return 9'(n);
    endfunction : phase_load

    // First input of the sweep group picked by the channel field.
    function automatic logic [2:0] group_first(input logic [2:0] ch);
        return {ch[2], 2'b00};
    endfunction : group_first

    ////////////////////////////////////////////////////////////////////////////////////////////
    // APB decode. Every register answers at once, so pready is never low.
    assign setup     = psel_i && !penable_i;
    assign access    = psel_i && penable_i;
    assign res_idx   = paddr_i[9:2];
    assign hit_csr   = reg_hit(paddr_i, `IDX_CSR);
    assign hit_tcr   = reg_hit(paddr_i, `IDX_TCR);
    assign hit_res   = reg_hit(paddr_i, `IDX_RES_A_HI) || reg_hit(paddr_i, `IDX_RES_A_LO)
                    || reg_hit(paddr_i, `IDX_RES_B_HI) || reg_hit(paddr_i, `IDX_RES_B_LO)
                    || reg_hit(paddr_i, `IDX_RES_C_HI) || reg_hit(paddr_i, `IDX_RES_C_LO)
                    || reg_hit(paddr_i, `IDX_RES_D_HI) || reg_hit(paddr_i, `IDX_RES_D_LO);
    assign mapped    = hit_csr || hit_tcr || hit_res;
    assign csr_wr    = access && pwrite_i && hit_csr;
    assign tcr_wr    = access && pwrite_i && hit_tcr;
    assign pready_o  = 1'b1;
    assign pslverr_o = access && !mapped;
    assign prdata_o  = s.prdata;
    assign ch_new    = pwdata_i[`CSR_CH_MSB:0];

    // Control/status image as software reads it.
    assign csr_val = {s.end_flag, s.irq_en, s.start, s.sweep, s.speed, s.ch};

    // Completion of a comparison phase; the result is stored on this edge.
    assign done = (s.phase == sar_adc_pkg::PH_CMP) && (s.cnt == 9'd0) && s.start;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Next state. Read side effects happen at the setup edge, where read data is also
    // captured, so a result landing between setup and access cannot split the two bytes.
    always_comb begin
        s_next = s;
        if (setup && !pwrite_i) begin
            s_next.prdata = 32'h0000_0000;
            if (hit_csr) begin
                s_next.prdata[7:0] = csr_val;
                s_next.armed       = s.end_flag;
            end else if (hit_tcr) begin
                s_next.prdata[7:0] = {s.trig_en, `TCR_RSVD};
            end else if (hit_res) begin
                s_next.prdata[7:0] = res_idx[0] ? res_hold : res_upper;
            end
        end
        // Register writes take effect at the access edge.
        if (csr_wr) begin
            s_next.irq_en = pwdata_i[`CSR_IRQEN];
            s_next.sweep  = pwdata_i[`CSR_SWEEP];
            s_next.speed  = pwdata_i[`CSR_SPEED];
            s_next.ch     = ch_new;
            s_next.start  = pwdata_i[`CSR_START] && (ch_new != `CH_RESERVED);
            if (s.armed && !pwdata_i[`CSR_FLAG]) s_next.end_flag = 1'b0;
            s_next.armed  = 1'b0;
        end
        if (tcr_wr) s_next.trig_en = pwdata_i[`TCR_TIMER_TRIGGER_ENABLE];
        // A trigger sets start only if enabled and idle of request.
        if (trigger_i && s.trig_en && !s.start && s.ch != `CH_RESERVED) begin
            s_next.start = 1'b1;
        end
        case (s.phase)
            sar_adc_pkg::PH_IDLE: begin
                if (s.start) begin
                    s_next.phase = sar_adc_pkg::PH_DELAY;
                    s_next.cnt   = phase_load(2'd0, s.speed);
                    s_next.cur   = s.sweep ? group_first(s.ch) : s.ch;
                end
            end
            sar_adc_pkg::PH_DELAY: begin
                if (s.cnt == 9'd0) begin
                    s_next.phase = sar_adc_pkg::PH_SAMPLE;
                    s_next.cnt   = phase_load(2'd1, s.speed);
                end else begin
                    s_next.cnt = s.cnt - 9'd1;
                end
            end
            sar_adc_pkg::PH_SAMPLE: begin
                if (s.cnt == 9'd0) begin
                    s_next.phase = sar_adc_pkg::PH_CMP;
                    s_next.cnt   = phase_load(2'd2, s.speed);
                end else begin
                    s_next.cnt = s.cnt - 9'd1;
                end
            end
            sar_adc_pkg::PH_CMP: begin
                if (s.cnt != 9'd0) begin
                    s_next.cnt = s.cnt - 9'd1;
                end else if (!s.start) begin
                    // A stop in the last cycle must neither store nor raise the flag.
                    s_next.phase = sar_adc_pkg::PH_IDLE;
                end else if (!s.sweep) begin
                    s_next.end_flag = 1'b1;
                    s_next.start    = 1'b0;
                    s_next.phase    = sar_adc_pkg::PH_IDLE;
                end else begin
                    // Sweep: next channel follows after a short gap so periods stay fixed.
                    s_next.phase = sar_adc_pkg::PH_DELAY;
                    s_next.cnt   = phase_load(2'd3, s.speed);
                    if (s.cur[1:0] == s.ch[1:0]) begin
                        s_next.end_flag = 1'b1;
                        s_next.cur      = group_first(s.ch);
                    end else begin
                        s_next.cur = s.cur + 3'd1;
                    end
                end
            end
            default: s_next.phase = sar_adc_pkg::PH_IDLE;
        endcase
        // Clearing start stops any conversion at once.
        if (!s.start) s_next.phase = sar_adc_pkg::PH_IDLE;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s          <= '0;
            s.phase    <= sar_adc_pkg::PH_IDLE;
        end else begin
            s <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Bit decisions run in the first ten states of the comparison phase.
    assign sar_load    = (s.phase == sar_adc_pkg::PH_SAMPLE);
    assign sar_step_en = (s.phase == sar_adc_pkg::PH_CMP) && !sar_done;

    sar_step u_sar (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .load_i       (sar_load),
        .step_i       (sar_step_en),
        .comparator_i (comparator_i),
        .code_o       (sar_code),
        .done_o       (sar_done)
    );

    // Inputs share a result register by their low two channel bits.
    result_bank u_bank (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .wr_i       (done),
        .wr_sel_i   (s.cur[1:0]),
        .wr_data_i  (sar_code),
        .rd_upper_i (setup && !pwrite_i && hit_res && !res_idx[0]),
        .rd_sel_i   (res_idx[2:1]),
        .upper_o    (res_upper),
        .hold_o     (res_hold)
    );

    // One driver for the whole front-end bundle: channel, sampling window, trial code.
    assign analog_o = {s.cur, s.phase == sar_adc_pkg::PH_SAMPLE, sar_code};
    assign conv_end_interrupt_o = s.end_flag && s.irq_en;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Checks. A sampling length counter helps the window check.
    logic [8:0] spl_cnt;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i)            spl_cnt <= 9'd0;
        else if (analog_o.sample) spl_cnt <= spl_cnt + 9'd1;
        else                     spl_cnt <= 9'd0;
    end

    // Cycles since the last store of the current run. The first store of a run is timed
    // from the idle exit and later ones from the previous store, so both figures are exact.
    logic [8:0] per_cnt;
    logic       per_run;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || s.phase == sar_adc_pkg::PH_IDLE) begin
            per_cnt <= 9'd0;
            per_run <= 1'b0;
        end else if (done) begin
            per_cnt <= 9'd0;
            per_run <= 1'b1;
        end else begin
            per_cnt <= per_cnt + 9'd1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_trig_ignored: assert property (
        trigger_i && !s.trig_en && !s.start && !csr_wr |=> !s.start)
        else $error("trigger started conversion while disabled");

    a_trig_starts: assert property (
        trigger_i && s.trig_en && !s.start && !csr_wr && s.ch != `CH_RESERVED
        |=> s.start ##1 s.phase == sar_adc_pkg::PH_DELAY)
        else $error("enabled trigger did not start conversion");

    a_tcr_ones: assert property (
        setup && !pwrite_i && hit_tcr |=> prdata_o[6:0] == `TCR_RSVD)
        else $error("trigger control unused bits not read as ones");

    a_single_end: assert property (
        done && !s.sweep && !csr_wr
        |=> !s.start && s.end_flag && s.phase == sar_adc_pkg::PH_IDLE)
        else $error("single completion did not end cleanly");

    a_single_hold: assert property (
        s.phase != sar_adc_pkg::PH_IDLE && !s.sweep && s.start && !done && !csr_wr
        |=> s.start)
        else $error("start flag dropped during a single conversion");

    a_flag_w1_noop: assert property (
        csr_wr && pwdata_i[`CSR_FLAG] && !s.end_flag && !done |=> !s.end_flag)
        else $error("writing one set the end flag");

    a_flag_unarmed: assert property (
        csr_wr && !s.armed && s.end_flag |=> s.end_flag)
        else $error("end flag cleared without a prior read of one");

    a_irq_rise: assert property (
        done && s.irq_en && !csr_wr && (!s.sweep || s.cur[1:0] == s.ch[1:0])
        |=> conv_end_interrupt_o)
        else $error("end interrupt missing");

    a_spl_window: assert property (
        $fell(analog_o.sample) && s.phase == sar_adc_pkg::PH_CMP
        |-> spl_cnt == (s.speed ? 9'd32 : 9'd64))
        else $error("sampling window length wrong");

    a_first_time: assert property (
        done && !per_run |-> per_cnt == (s.speed ? 9'd129 : 9'd257))
        else $error("first conversion time wrong");

    a_period_fixed: assert property (
        done && per_run |-> per_cnt == (s.speed ? 9'd127 : 9'd255))
        else $error("sweep conversion period wrong");

    a_sweep_first: assert property (
        s.phase == sar_adc_pkg::PH_IDLE && s.start && s.sweep
        |=> s.cur == group_first($past(s.ch)))
        else $error("sweep did not begin at group first input");

    a_sweep_next: assert property (
        done && s.sweep && s.cur[1:0] != s.ch[1:0] && !csr_wr
        |=> s.cur == $past(s.cur) + 3'd1 && s.phase == sar_adc_pkg::PH_DELAY)
        else $error("sweep did not advance to the next input");

    a_sweep_wrap: assert property (
        done && s.sweep && s.cur[1:0] == s.ch[1:0] && !csr_wr
        |=> s.end_flag && s.cur == group_first($past(s.ch))
            && s.phase == sar_adc_pkg::PH_DELAY)
        else $error("sweep round did not flag and wrap");

    a_stop_idle: assert property (
        s.phase != sar_adc_pkg::PH_IDLE && !s.start
        |=> s.phase == sar_adc_pkg::PH_IDLE)
        else $error("conversion continued after start cleared");

    a_delay_slow: assert property (
        $rose(s.start) && !s.speed && s.phase == sar_adc_pkg::PH_IDLE && !csr_wr
        |-> ##9 !analog_o.sample ##1 analog_o.sample)
        else $error("slow start delay wrong");

    a_delay_fast: assert property (
        $rose(s.start) && s.speed && s.phase == sar_adc_pkg::PH_IDLE && !csr_wr
        |-> ##5 !analog_o.sample ##1 analog_o.sample)
        else $error("fast start delay wrong");

    a_reserved_ch: assert property (
        csr_wr && pwdata_i[`CSR_START] && ch_new == `CH_RESERVED && !s.start && !trigger_i
        |=> !s.start)
        else $error("reserved channel code started a conversion");

    a_low_zero: assert property (
        setup && !pwrite_i && hit_res && res_idx[0] |=> prdata_o[5:0] == 6'h00)
        else $error("lower byte reserved bits set");

    c_single_done: cover property (done && !s.sweep);
    c_sweep_round: cover property (done && s.sweep && s.cur[1:0] == s.ch[1:0]);
    c_trig_start:  cover property (trigger_i && s.trig_en && !s.start);
    c_flag_clear:  cover property (csr_wr && s.armed && !pwdata_i[`CSR_FLAG]);
endmodule : sar_adc_sequencer

/* File: core/sar_step.sv */
/*
 * Successive-approximation register: one result bit decided per step.
 * Assumes comparator_i is high when the held input is at or above dac code.
 */
`timescale 1ns/100ps
module sar_step (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       load_i,
    input  wire logic       step_i,
    input  wire logic       comparator_i,
    output logic [9:0]      code_o,
    output logic            done_o
);
    sar_adc_pkg::sar_state_s s, s_next;

    // Trial bit kept or dropped, next lower bit tried; done when the mask runs out.
    always_comb begin
        s_next = s;
        if (load_i) begin
            s_next.code = 10'h200;
            s_next.mask = 10'h200;
        end else if (step_i && s.mask != 10'h000) begin
            s_next.code = (comparator_i ? s.code : (s.code & ~s.mask)) | (s.mask >> 1);
            s_next.mask = s.mask >> 1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) s <= '0;
        else          s <= s_next;
    end

    assign code_o = s.code;
    assign done_o = (s.mask == 10'h000);
endmodule : sar_step

/* File: verif/analog_front.sv */
/* Analog front end model: a fixed level per input, held while the sequencer samples.
   Assumes channel, sample and dac_code come from the sequencer on clk_i. */
`timescale 1ns/100ps
module analog_front (
    input  wire logic                     clk_i,
    input  wire sar_adc_pkg::analog_out_s a_i,
    output logic                          cmp_o
);
    logic [9:0] held = 10'h000;
    // Distinct level per input, with low bits set for every input but input 3 so the lower byte is exercised.
    function automatic logic [9:0] lvl(input logic [2:0] c);
        return 10'h0C5 + 10'h091 * c;
    endfunction : lvl
    // The level is frozen outside the window, as a real hold capacitor would be.
    always @(posedge clk_i) begin
        if (a_i.sample) held <= lvl(a_i.channel);
    end
    assign cmp_o = (held >= a_i.dac_code);
endmodule : analog_front

/* File: verif/testbench.sv */
/* Self-checking bench of the converter sequencer over APB.
   Assumes the analog_front model and the fixed fast/slow timings of the sequencer. */
`timescale 1ns/100ps
`include "sar_adc_defs.svh"
module testbench;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, trig = 1'b0, cmp, pready, pslverr, irq, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    sar_adc_pkg::analog_out_s ana;
    int          miscompares = 0, samples_checked = 0;
    sar_adc_sequencer uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .trigger_i(trig), .comparator_i(cmp),
        .analog_o(ana), .conv_end_interrupt_o(irq));
    analog_front afe (.clk_i(clk_i), .a_i(ana), .cmp_o(cmp));
    // Free-running 125 MHz clock.
    always #4 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [9:0] lv(input logic [2:0] c);
        return 10'h0C5 + 10'h091 * c;
    endfunction : lv
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checked %0d, miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    // One APB transfer; the request stands until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1 && k < 64) begin
            @(posedge clk_i);
            k++;
        end
        if (k == 64) begin
            miscompares++;
            end_of_test();
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(r, {24'h0, exp});
    endtask : rd
    // Result of input c: upper byte first, so the lower byte comes from a fresh copy.
    task automatic res(input logic [2:0] c);
        logic [9:0] v;
        v = lv(c);
        rd(`IDX_RES_A_HI + {5'h0, c[1:0], 1'b0}, v[9:2]);
        rd(`IDX_RES_A_LO + {5'h0, c[1:0], 1'b0}, {v[1:0], 6'h00});
    endtask : res
    // Counts edges until the interrupt request shows; a run-away wait ends the run.
    task automatic wirq(input int exp);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk(n, exp);
        if (n == 2000) end_of_test();
    endtask : wirq
    task automatic pulse;
        @(posedge clk_i);
        trig <= 1'b1;
        @(posedge clk_i);
        trig <= 1'b0;
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(`IDX_CSR, 8'h00);
        apb(1'b1, `IDX_TCR, 8'h00);
        rd(`IDX_TCR, 8'h7F);
        rd(`IDX_RES_A_HI, 8'h00);
        apb(1'b0, 8'h2A, 8'h00);
        chk(err, 32'h1);
        $display("test reset done");
        apb(1'b1, `IDX_CSR, 8'h69);
        wirq(131);
        rd(`IDX_CSR, 8'hC9);
        res(3'd1);
        apb(1'b1, `IDX_CSR, 8'hC9);
        rd(`IDX_CSR, 8'hC9);
        apb(1'b1, `IDX_CSR, 8'h49);
        rd(`IDX_CSR, 8'h49);
        chk(irq, 32'h0);
        $display("test single done");
        apb(1'b1, `IDX_CSR, 8'h4E);
        pulse();
        rd(`IDX_CSR, 8'h4E);
        apb(1'b1, `IDX_TCR, 8'hFF);
        pulse();
        pulse();
        wirq(129);
        res(3'd6);
        rd(`IDX_CSR, 8'hCE);
        apb(1'b1, `IDX_CSR, 8'h4E);
        apb(1'b1, `IDX_TCR, 8'h7F);
        $display("test trigger done");
        apb(1'b1, `IDX_CSR, 8'h7E);
        wirq(387);
        for (int c = 4; c < 7; c++) res(c[2:0]);
        rd(`IDX_CSR, 8'hFE);
        apb(1'b1, `IDX_CSR, 8'h5E);
        apb(1'b1, `IDX_CSR, 8'h71);
        wirq(515);
        res(3'd0);
        res(3'd1);
        rd(`IDX_CSR, 8'hF1);
        apb(1'b1, `IDX_CSR, 8'h40);
        $display("test sweep done");
        apb(1'b1, `IDX_CSR, 8'h63);
        wirq(259);
        res(3'd3);
        apb(1'b1, `IDX_CSR, 8'h67);
        rd(`IDX_CSR, 8'hC7);
        $display("test slow done");
        end_of_test();
    end
endmodule : testbench
